// >>> ssoc_serdes_ctrl.sv
// serializer sync burst, word strobe and deserializer lock / output control with APB registers
// Notes on behaviour
// [R01] The two sync request inputs act as one request, their logical OR.
// [R02] A request held high for 6 transmit clock cycles starts a burst of at least 1026 sync patterns.
// [R03] If the request is still high when the 1026-pattern burst ends, sync patterns go on until it falls.
// [R04] A later request held high past six cycles starts a fresh 1026-pattern burst.
// [R05] The parallel word is latched on the falling transmit clock edge when edge select is low, rising when high.
// [R06] The transmit clock both strobes each parallel word in and paces the serializer output.
// [R07] The active-low lock indicator goes low once the receive PLL is locked to the serial stream.
// [R08] The controlling party holds power-down low at least 16 ns to start power down.
// [R09] While power-down is low the receiver stays down, PLL off and outputs in high impedance.
// [R10] The recovered word launches against the falling recovered clock edge for select low, rising for high.
// [R11] With receive output enable low the ten data outputs and the recovered clock are high impedance.
// [R12] Receiving logic captures the parallel data using the recovered clock as its strobe.
// [R13] The system supplies a reference clock so the receive PLL has a frequency reference.
// [R14] While unlocked the data outputs and recovered clock are high impedance.
// [R15] The serial output is high impedance while serial drive enable is low and driven while it is high.
// [R16] Each recovered word is presented with one recovered clock period while locked and enabled.
//
// The APB register port and the register offsets were chosen for this implementation.
module ssoc_serdes_ctrl
	import ssoc_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	output logic irq,
	// serializer parallel side
	input wire logic transmit_clock,
	input wire logic [ssoc_pkg::WORD_W-1:0] tx_parallel_word,
	input wire logic sync_request_a,
	input wire logic sync_request_b,
	// serializer link side
	output logic [ssoc_pkg::WORD_W-1:0] serialWord,
	output logic serialIsSync,
	output logic serialWordStrobe,
	output logic serialOe,
	// deserializer link side
	input wire logic rx_reference_clock,
	input wire logic rxPllLocked,
	input wire logic [ssoc_pkg::WORD_W-1:0] rxLinkWord,
	input wire logic rxLinkValid,
	// deserializer parallel side
	output logic [ssoc_pkg::WORD_W-1:0] rx_parallel_word,
	output logic rxParallelWordOe,
	output logic recClk,
	output logic recClkOe,
	output logic lockN,
	output logic lockNOe
);
	import ssoc_pkg::*;

	function automatic logic edgeSel(input logic selRising, input logic rise, input logic fall);
		edgeSel = selRising ? rise : fall;
	endfunction : edgeSel

	// registers
	logic [CTRL_W-1:0] ctrl_r;
	logic [INT_W-1:0] intStat_r;
	logic [INT_W-1:0] intMask_r;
	logic [31:0] prdata_r;
	// serializer state
	logic txClkPrev_r;
	logic [WORD_W-1:0] txLatched_r;
	logic [2:0] highCnt_r;
	logic [10:0] burstCnt_r;
	ssoc_sync_e syncState_r;
	ssoc_sync_e syncState_nxt;
	logic [WORD_W-1:0] serialWord_r;
	logic serialIsSync_r;
	logic serialStrobe_r;
	// deserializer state
	logic refPrev_r;
	logic [7:0] refIdle_r;
	logic [3:0] pdCnt_r;
	logic poweredDown_r;
	logic locked_r;
	logic [WORD_W-1:0] rxWord_r;
	logic recClk_r;
	logic [3:0] halfCnt_r;

	// apb decode
	wire logic setupPhase = psel & ~penable;
	wire logic accessPhase = psel & penable;
	wire logic hitCtrl = (paddr == ADDR_CTRL);
	wire logic hitStatus = (paddr == ADDR_STATUS);
	wire logic hitIntStat = (paddr == ADDR_INT_STATUS);
	wire logic hitIntMask = (paddr == ADDR_INT_MASK);
	wire logic hitTxLatched = (paddr == ADDR_TX_LATCHED);
	wire logic hitRxWord = (paddr == ADDR_RX_WORD);
	wire logic addrMapped = hitCtrl | hitStatus | hitIntStat | hitIntMask | hitTxLatched | hitRxWord;
	wire logic wrStrobe = accessPhase & pwrite & addrMapped;
	wire logic wrCtrl = wrStrobe & hitCtrl;
	wire logic wrIntStat = wrStrobe & hitIntStat;
	wire logic wrIntMask = wrStrobe & hitIntMask;

	// control fields
	wire logic txEdgeSel = ctrl_r[CTRL_TX_EDGE];
	wire logic rxEdgeSel = ctrl_r[CTRL_RX_EDGE];
	wire logic serialDriveEn = ctrl_r[CTRL_DRIVE_EN];
	wire logic rxOutEn = ctrl_r[CTRL_OUT_EN];
	wire logic powerDownN = ctrl_r[CTRL_PWR_N];

	// transmit clock edges
	wire logic txRise = transmit_clock & ~txClkPrev_r;
	wire logic txFall = ~transmit_clock & txClkPrev_r;
	wire logic txLoad = edgeSel(txEdgeSel, txRise, txFall); // [R05]
	wire logic syncReq = sync_request_a | sync_request_b; // [R01]
	wire logic holdMet = syncReq & (highCnt_r == SYNC_HOLD_CYCLES - 3'h1); // [R02]
	wire logic burstLast = (burstCnt_r == SYNC_BURST_LEN - 11'h001);
	wire logic sendSync = (syncState_r != SS_IDLE);

	// sync sequencer
	always_comb begin
		syncState_nxt = syncState_r;
		if (txRise) begin
			unique case (syncState_r)
				SS_IDLE: begin
					if (holdMet) begin
						syncState_nxt = SS_BURST; // [R02] [R04]
					end
				end
				SS_BURST: begin
					if (burstLast) begin
						syncState_nxt = syncReq ? SS_HOLD : SS_IDLE; // [R03]
					end
				end
				SS_HOLD: begin
					if (!syncReq) begin
						syncState_nxt = SS_IDLE; // [R03]
					end
				end
				default: begin
					syncState_nxt = SS_IDLE;
				end
			endcase
		end
	end

	wire logic burstStart = txRise & (syncState_r == SS_IDLE) & holdMet;
	wire logic burstDone = txRise & (syncState_r == SS_BURST) & burstLast;

	// reference clock watch and lock
	wire logic refEdge = rx_reference_clock ^ refPrev_r;
	wire logic refOk = (refIdle_r < REF_TIMEOUT_CYC); // [R13]
	wire logic lockNow = rxPllLocked & refOk & ~poweredDown_r; // [R07] [R09]
	wire logic lockGain = lockNow & ~locked_r;
	wire logic lockLoss = ~lockNow & locked_r;
	wire logic rxDeliver = locked_r & rxOutEn & ~poweredDown_r; // [R14] [R11]
	wire logic rxTake = rxLinkValid & lockNow;

	// interrupt events
	wire logic [INT_W-1:0] intEvents = {lockLoss, lockGain, burstDone, burstStart};
	wire logic [INT_W-1:0] intClear = wrIntStat ? pwdata[INT_W-1:0] : {INT_W{1'b0}};

	// read mux
	wire logic [31:0] statusWord = {28'h0000000, refOk, ~poweredDown_r, sendSync, locked_r};
	wire logic [31:0] readMux = hitCtrl ? {27'h0000000, ctrl_r} :
		hitStatus ? statusWord :
		hitIntStat ? {28'h0000000, intStat_r} :
		hitIntMask ? {28'h0000000, intMask_r} :
		hitTxLatched ? {22'h000000, txLatched_r} :
		hitRxWord ? {22'h000000, rxWord_r} : 32'h00000000;

	// apb and interrupt registers
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r <= CTRL_RESET;
			intMask_r <= INT_MASK_RESET;
			intStat_r <= {INT_W{1'b0}};
			prdata_r <= 32'h00000000;
		end else begin
			if (wrCtrl) begin
				ctrl_r <= pwdata[CTRL_W-1:0];
			end
			if (wrIntMask) begin
				intMask_r <= pwdata[INT_W-1:0];
			end
			intStat_r <= (intStat_r & ~intClear) | intEvents;
			if (setupPhase) begin
				prdata_r <= readMux;
			end
		end
	end

	// serializer datapath
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			txClkPrev_r <= 1'b0;
			txLatched_r <= {WORD_W{1'b0}};
			highCnt_r <= 3'h0;
			burstCnt_r <= 11'h000;
			syncState_r <= SS_IDLE;
			serialWord_r <= {WORD_W{1'b0}};
			serialIsSync_r <= 1'b0;
			serialStrobe_r <= 1'b0;
		end else begin
			txClkPrev_r <= transmit_clock;
			syncState_r <= syncState_nxt;
			serialStrobe_r <= txRise; // [R06]
			if (txLoad) begin
				txLatched_r <= tx_parallel_word; // [R05] [R06]
			end
			if (txRise) begin
				if (!syncReq) begin
					highCnt_r <= 3'h0; // [R04]
				end else if (highCnt_r != SYNC_HOLD_CYCLES) begin
					highCnt_r <= highCnt_r + 3'h1; // [R02]
				end
				burstCnt_r <= (syncState_nxt == SS_BURST && syncState_r == SS_BURST) ? burstCnt_r + 11'h001 : 11'h000;
				serialWord_r <= (syncState_nxt != SS_IDLE) ? SYNC_PATTERN : txLatched_r;
				serialIsSync_r <= (syncState_nxt != SS_IDLE);
			end
		end
	end

	// deserializer power, lock and word presentation
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			refPrev_r <= 1'b0;
			refIdle_r <= REF_TIMEOUT_CYC;
			pdCnt_r <= 4'h0;
			poweredDown_r <= 1'b0;
			locked_r <= 1'b0;
			rxWord_r <= {WORD_W{1'b0}};
			recClk_r <= 1'b0;
			halfCnt_r <= 4'h0;
		end else begin
			refPrev_r <= rx_reference_clock;
			if (refEdge) begin
				refIdle_r <= RESET_ZERO8;
			end else if (refOk) begin
				refIdle_r <= refIdle_r + 8'h01;
			end
			if (powerDownN) begin
				pdCnt_r <= 4'h0;
				poweredDown_r <= 1'b0;
			end else if (pdCnt_r != POWER_DOWN_N_MIN_CYC) begin
				pdCnt_r <= pdCnt_r + 4'h1; // [R08]
				poweredDown_r <= (pdCnt_r + 4'h1 == POWER_DOWN_N_MIN_CYC); // [R09]
			end
			locked_r <= lockNow; // [R07]
			if (rxTake) begin
				rxWord_r <= rxLinkWord; // [R10] [R16]
				recClk_r <= ~rxEdgeSel;
				halfCnt_r <= RCLK_HALF_CYC;
			end else if (halfCnt_r != 4'h0) begin
				halfCnt_r <= halfCnt_r - 4'h1;
				if (halfCnt_r == 4'h1) begin
					recClk_r <= rxEdgeSel; // [R10] [R12] [R16]
				end
			end
		end
	end

	// outputs
	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = accessPhase & ~addrMapped;
	assign irq = |(intStat_r & intMask_r);
	assign serialWord = serialWord_r;
	assign serialIsSync = serialIsSync_r;
	assign serialWordStrobe = serialStrobe_r;
	assign serialOe = serialDriveEn; // [R15]
	assign rx_parallel_word = rxWord_r;
	assign rxParallelWordOe = rxDeliver; // [R11] [R14]
	assign recClk = recClk_r;
	assign recClkOe = rxDeliver; // [R11] [R14]
	assign lockN = ~locked_r; // [R07]
	assign lockNOe = ~poweredDown_r; // [R09]

	// assertions
	sequence s_holdSix;
		syncReq && txRise && syncState_r == SS_IDLE && highCnt_r == 3'h5;
	endsequence

	sequence s_burstEnd;
		txRise && syncState_r == SS_BURST && burstLast;
	endsequence

	a_sync_or_req: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R01]
		(sync_request_a || sync_request_b) && txRise && highCnt_r != SYNC_HOLD_CYCLES |=>
		highCnt_r == $past(highCnt_r) + 3'h1)
		else $error("sync request is not the OR of both inputs");

	a_burst_start: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R02]
		s_holdSix |=> syncState_r == SS_BURST && burstCnt_r == 11'h000)
		else $error("burst did not start after six held cycles");

	a_burst_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R03]
		s_burstEnd and (syncReq) |=> syncState_r == SS_HOLD)
		else $error("sync did not continue while request held");

	a_burst_length: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R02]
		(syncState_r == SS_BURST && txRise && !burstLast) |=> syncState_r == SS_BURST)
		else $error("burst ended before its full pattern count");

	a_rearm_idle: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R04]
		(txRise && !syncReq) |=> highCnt_r == 3'h0 && syncState_r != SS_HOLD)
		else $error("request low did not rearm sync counter");

	a_tx_latch_edge: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R05]
		(txEdgeSel && txFall && !txRise) |=> txLatched_r == $past(txLatched_r))
		else $error("word latched on the wrong transmit edge");

	a_lock_low: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R07]
		lockNow ##1 lockNow |=> !lockN)
		else $error("lock indicator not low after lock");

	a_power_down_n_hiz: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R09]
		poweredDown_r |-> !lockNOe && !rxParallelWordOe && !recClkOe ##1 !locked_r)
		else $error("outputs driven while powered down");

	a_out_enable: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R11]
		(!rxOutEn || lockN) |-> !rxParallelWordOe && !recClkOe)
		else $error("receive outputs driven while disabled or unlocked");

	a_rclk_phase: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R10]
		rxTake |=> recClk_r == !$past(rxEdgeSel) ##1 recClk_r == $past(rxEdgeSel) || $past(rxTake))
		else $error("recovered clock edge does not follow edge select");

	a_serial_oe: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R15]
		$rose(ctrl_r[CTRL_DRIVE_EN]) |-> serialOe ##0 !$past(serialOe))
		else $error("serial output enable does not follow drive enable");

	sequence s_pdEnter;
		!powerDownN && !poweredDown_r;
	endsequence

	a_power_down_n_enter: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R09]
		s_pdEnter ##1 !powerDownN |-> poweredDown_r)
		else $error("power down not entered while held low");

	a_burst_flag: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R02]
		burstStart |=> intStat_r[INT_BURST_START])
		else $error("burst start event not flagged");
endmodule : ssoc_serdes_ctrl

// >>> ssoc_pkg.sv
// constants, register map and types for the serdes sync and output control block
package ssoc_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h08;
	localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
	localparam logic [7:0] ADDR_TX_LATCHED = 8'h10;
	localparam logic [7:0] ADDR_RX_WORD = 8'h14;
	// control register fields
	localparam int CTRL_TX_EDGE = 0;
	localparam int CTRL_RX_EDGE = 1;
	localparam int CTRL_DRIVE_EN = 2;
	localparam int CTRL_OUT_EN = 3;
	localparam int CTRL_PWR_N = 4;
	localparam int CTRL_W = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h1C;
	// status register fields
	localparam int STAT_LOCKED = 0;
	localparam int STAT_SYNC_BUSY = 1;
	localparam int STAT_POWERED = 2;
	localparam int STAT_REF_OK = 3;
	// interrupt fields
	localparam int INT_BURST_START = 0;
	localparam int INT_BURST_DONE = 1;
	localparam int INT_LOCK_GAIN = 2;
	localparam int INT_LOCK_LOSS = 3;
	localparam int INT_W = 4;
	localparam logic [INT_W-1:0] INT_MASK_RESET = 4'h0;
	// word and sync figures
	localparam int WORD_W = 10;
	localparam logic [2:0] SYNC_HOLD_CYCLES = 3'h6;
	localparam logic [10:0] SYNC_BURST_LEN = 11'h402;
	localparam logic [WORD_W-1:0] SYNC_PATTERN = 10'h3E0;
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int POWER_DOWN_N_MIN_NS = 16;
	localparam int POWER_DOWN_N_MIN_CYC_RAW = (POWER_DOWN_N_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] POWER_DOWN_N_MIN_CYC = 4'((POWER_DOWN_N_MIN_CYC_RAW < 1) ? 1 : POWER_DOWN_N_MIN_CYC_RAW);
	localparam int REF_MAX_PERIOD_NS = 1000;
	localparam logic [7:0] REF_TIMEOUT_CYC = 8'(REF_MAX_PERIOD_NS / CLK_PERIOD_NS);
	localparam logic [3:0] RCLK_HALF_CYC = 4'h1;
	localparam logic [7:0] RESET_ZERO8 = 8'h00;
	typedef enum logic [1:0] {
		SS_IDLE = 2'b00,
		SS_BURST = 2'b01,
		SS_HOLD = 2'b11
	} ssoc_sync_e;
endpackage : ssoc_pkg

// >>> ssoc_link_model.sv
// far-side model: transmit clock source, reference clock and receive link
module ssoc_link_model
	import ssoc_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// bench control
	input wire logic txRun,
	input wire logic lockEn,
	// clocks toward the block
	output logic transmit_clock,
	output logic rx_reference_clock,
	// receive link
	output logic rxPllLocked,
	output logic [ssoc_pkg::WORD_W-1:0] rxLinkWord,
	output logic rxLinkValid
);
	import ssoc_pkg::*;
	logic [1:0] phase_r;
	logic [WORD_W-1:0] seq_r;
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase_r <= 2'h0;
			seq_r <= 10'h001;
			transmit_clock <= 1'b0;
			rx_reference_clock <= 1'b0;
			rxPllLocked <= 1'b0;
			rxLinkWord <= 10'h000;
			rxLinkValid <= 1'b0;
		end else begin
			phase_r <= phase_r + 2'h1;
			// 12.5 MHz, finishes its high half before stopping
			if (phase_r[0] && (txRun || transmit_clock))
				transmit_clock <= !transmit_clock;
			if (phase_r == 2'h3)
				rx_reference_clock <= !rx_reference_clock;
			rxPllLocked <= lockEn;
			rxLinkValid <= (phase_r == 2'h0) && rxPllLocked;
			// idle link data flips every cycle
			rxLinkWord <= (phase_r == 2'h0) ? seq_r : ~rxLinkWord;
			if (phase_r == 2'h0)
				seq_r <= seq_r + 10'h07B;
		end
	end
endmodule : ssoc_link_model

// >>> ssoc_serdes_ctrl_tb.sv
// testbench for the serdes sync and output control block
module ssoc_serdes_ctrl_tb;
	import ssoc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, irq;
	logic transmit_clock, rx_reference_clock, rxPllLocked, rxLinkValid;
	logic [WORD_W-1:0] rxLinkWord, serialWord, rx_parallel_word, lastSent;
	logic [WORD_W-1:0] tx_parallel_word = 10'h000;
	logic sync_request_a = 1'b0;
	logic sync_request_b = 1'b0;
	logic txRun = 1'b1;
	logic lockEn = 1'b0;
	logic serialIsSync, serialWordStrobe, serialOe, rxParallelWordOe, recClk, recClkOe, lockN, lockNOe;
	logic [31:0] rd;
	logic er;
	int failures = 0;
	int checksDone = 0;
	int cyc = 0;
	int syncCnt = 0;
	int base;
	ssoc_serdes_ctrl ssoc_serdes_ctrl_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .transmit_clock(transmit_clock), .tx_parallel_word(tx_parallel_word),
		.sync_request_a(sync_request_a), .sync_request_b(sync_request_b), .serialWord(serialWord),
		.serialIsSync(serialIsSync), .serialWordStrobe(serialWordStrobe), .serialOe(serialOe),
		.rx_reference_clock(rx_reference_clock), .rxPllLocked(rxPllLocked), .rxLinkWord(rxLinkWord),
		.rxLinkValid(rxLinkValid), .rx_parallel_word(rx_parallel_word), .rxParallelWordOe(rxParallelWordOe),
		.recClk(recClk), .recClkOe(recClkOe), .lockN(lockN), .lockNOe(lockNOe));
	ssoc_link_model ssoc_link_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .txRun(txRun), .lockEn(lockEn),
		.transmit_clock(transmit_clock), .rx_reference_clock(rx_reference_clock), .rxPllLocked(rxPllLocked),
		.rxLinkWord(rxLinkWord), .rxLinkValid(rxLinkValid));
	always #10 sys_clk = ~sys_clk;
	task automatic test_done;
		if (failures == 0 && checksDone > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			$display("[ERR] %0t timeout", $time);
			test_done();
		end
	end
	// monitors sample mid-cycle
	always @(negedge sys_clk) begin
		if (serialWordStrobe === 1'b1 && serialIsSync === 1'b1) begin
			syncCnt++;
			checksDone++;
			if (serialWord !== SYNC_PATTERN) begin
				failures++;
				$display("[ERR] %0t sync word %h", $time, serialWord);
			end
		end
		if (rxLinkValid === 1'b1)
			lastSent = rxLinkWord;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
		@(negedge sys_clk);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		chk(rd, exp);
	endtask : rdc
	task automatic strobes(input int n);
		repeat (n) begin
			do @(negedge sys_clk); while (serialWordStrobe !== 1'b1);
		end
	endtask : strobes
	task automatic waitIdle;
		while (serialIsSync !== 1'b0) begin
			@(negedge sys_clk);
		end
	endtask : waitIdle
	initial begin
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rdc(ADDR_CTRL, 32'h1C);
		rdc(ADDR_INT_MASK, 32'h0);
		xfer(8'h18, 1'b0, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		chk({29'h0, lockN, rxParallelWordOe, recClkOe}, 32'h4);
		@(posedge sys_clk) lockEn <= 1'b1;
		repeat (80) @(posedge sys_clk);
		rdc(ADDR_STATUS, 32'hD);
		chk({28'h0, lockN, lockNOe, rxParallelWordOe, recClkOe}, 32'h7);
		for (int s = 0; s < 2; s++) begin
			wr(ADDR_CTRL, 32'h1C | (s << 1));
			repeat (2) begin
				if (s == 1) @(posedge recClk); else @(negedge recClk);
			end
			chk({22'h0, rx_parallel_word}, {22'h0, lastSent});
		end
		wr(ADDR_CTRL, 32'h14);
		chk({28'h0, lockN, lockNOe, rxParallelWordOe, recClkOe}, 32'h4);
		wr(ADDR_CTRL, 32'h0C);
		@(negedge sys_clk);
		chk({29'h0, lockNOe, rxParallelWordOe, recClkOe}, 32'h0);
		wr(ADDR_CTRL, 32'h18);
		chk({31'h0, serialOe}, 32'h0);
		wr(ADDR_CTRL, 32'h1C);
		chk({31'h0, serialOe}, 32'h1);
		for (int s = 0; s < 2; s++) begin
			wr(ADDR_CTRL, 32'h1C | s);
			@(posedge sys_clk) txRun <= 1'b0;
			tx_parallel_word <= 10'h155;
			repeat (8) @(posedge sys_clk);
			txRun <= 1'b1;
			@(posedge transmit_clock);
			@(posedge sys_clk) txRun <= 1'b0;
			tx_parallel_word <= 10'h2AA;
			@(negedge transmit_clock);
			repeat (4) @(posedge sys_clk);
			rdc(ADDR_TX_LATCHED, (s == 1) ? 32'h155 : 32'h2AA);
		end
		@(posedge sys_clk) txRun <= 1'b1;
		base = syncCnt;
		sync_request_a <= 1'b1;
		strobes(1200);
		chk({31'h0, serialIsSync}, 32'h1);
		@(posedge sys_clk) sync_request_a <= 1'b0;
		waitIdle();
		chk({31'h0, syncCnt - base > 1026}, 32'h1);
		wr(ADDR_INT_STATUS, 32'hF);
		base = syncCnt;
		@(posedge sys_clk) sync_request_b <= 1'b1;
		strobes(20);
		@(posedge sys_clk) sync_request_b <= 1'b0;
		waitIdle();
		chk(32'(syncCnt - base), 32'd1026);
		rdc(ADDR_INT_STATUS, 32'h3);
		chk({31'h0, irq}, 32'h0);
		wr(ADDR_INT_MASK, 32'h2);
		chk({31'h0, irq}, 32'h1);
		wr(ADDR_INT_STATUS, 32'h2);
		chk({31'h0, irq}, 32'h0);
		rdc(ADDR_INT_STATUS, 32'h1);
		test_done();
	end
endmodule : ssoc_serdes_ctrl_tb
